// ===== hdl/pdr_top.sv
// Digital control of the clock synthesiser: dividers, delays, switchover,
// serial reconfiguration. Assumes ref clocks and shift pins are asynchronous.
// What this block does
// [RL1] One pre-divide and one multiply counter, each 1 to 512.
// [RL2] Two regional, four global, four external post counters, 1-1024.
// [RL3] Non-half-period duty limits post counters to 1 through 512.
// [RL4] Oscillator target equals reference times multiply over pre-divide.
// [RL5] Each output owns its post counter dividing the oscillator.
// [RL6] Phase step is one eighth of the oscillator period.
// [RL7] Delay element steps 250 ps over plus or minus 3 ns.
// [RL8] Six internal clock outputs; external feedback input selectable. CTRL_FEXT_BIT is kept in the control register but drives nothing.
// [RL9] Auto switchover moves to secondary when primary stops toggling.
// [RL10] Manual switch request forces reference change.
// [RL11] Other party switches manually when frequencies differ over 20%.
// [RL12] Reference change is glitch free; oscillator keeps running.
// [RL13] Lock must return within 100 us after switchover.
// [RL14] Other party may combine switch request with lock indication.
// [RL15] Reconfiguration touches only counters and delay settings.
// [RL16] Other party shifts chain bits, one per shift clock edge.
// [RL17] After final bit, chain loads into active bits at once.
// [RL18] Chain has asynchronous clear for all stages.
// [RL19] At 22 MHz shift clock, reconfiguration completes under 20 us.
// [RL20] Per-input missing flags, combined loss, active reference reported.
`timescale 1ns/1ps
module pdr_top
	import pdr_pkg::*;
#(
	parameter int RELOCK_LIMIT = RELOCK_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        primary_ref_input,
	input  wire logic        secondary_ref_input,
	input  wire logic        vco_clock,
	input  wire logic        pll_locked,
	input  wire logic        switch_request,
	input  wire logic        shift_clock,
	input  wire logic        shift_data,
	input  wire logic        shift_clear,
	output logic             ref_select,
	output logic             primary_missing_flag,
	output logic             secondary_missing_flag,
	output logic             reference_loss_flag,
	output logic             relock_timeout,
	output logic [NUM_OUT-1:0] post_outs
);
	// ==========================================================
	// Shift chain on its own clock, async clear
	logic [CHAIN_LEN-1:0] chain_q;
	logic [7:0]           bitcnt_q;
	logic                 done_tg_q;
	// [RL16] One bit per shift edge
	// [RL18] Async clear of every stage
	always_ff @(posedge shift_clock or posedge shift_clear) begin
		if (shift_clear) begin
			chain_q   <= '0;
			bitcnt_q  <= 8'h00;
			done_tg_q <= 1'b0;
		end else begin
			chain_q <= {shift_data, chain_q[CHAIN_LEN-1:1]};
			if (bitcnt_q == 8'(CHAIN_LEN - 1)) begin
				bitcnt_q  <= 8'h00;
				done_tg_q <= ~done_tg_q;
			end else begin
				bitcnt_q <= bitcnt_q + 8'h01;
			end
		end
	end
	// ==========================================================
	// Synchronisers
	logic [2:0] s1_q, s2_q;
	logic       done_seen_q, ref_a_q, ref_b_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_q <= 3'h0; s2_q <= 3'h0;
			done_seen_q <= 1'b0; ref_a_q <= 1'b0; ref_b_q <= 1'b0;
		end else begin
			s1_q <= {done_tg_q, secondary_ref_input, primary_ref_input};
			s2_q <= s1_q;
			done_seen_q <= s2_q[2];
			ref_a_q <= s2_q[0];
			ref_b_q <= s2_q[1];
		end
	end
	wire load_evt = s2_q[2] ^ done_seen_q;
	wire sw_req   = switch_request;
	// ==========================================================
	// Config registers
	logic [31:0] ctrl_q, ctrl_d;
	logic [9:0]  ndiv_q, ndiv_d, mdiv_q, mdiv_d;
	logic [9:0]  post_q [NUM_OUT];
	logic [9:0]  post_d [NUM_OUT];
	logic [NUM_OUT-1:0] half_q, half_d;
	logic [4:0]  dly_q [NUM_OUT];
	logic [4:0]  dly_d [NUM_OUT];
	logic        wr_pend_q, rd_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] hrdata_d;

	function automatic logic [9:0] clamp(input logic [10:0] v,
	                                     input logic [10:0] mx);
		if (v == 11'h000)
			return 10'h001;
		else if (v > mx)
			return 10'(mx);
		else
			return 10'(v);
	endfunction

	always_comb begin
		ctrl_d = ctrl_q;
		ndiv_d = ndiv_q;
		mdiv_d = mdiv_q;
		post_d = post_q;
		half_d = half_q;
		dly_d  = dly_q;
		if (load_evt) begin
			// [RL17] Whole chain loads at once
			// [RL15] Only counters and delays change
			ndiv_d = clamp({1'b0, chain_q[9:0]}, 11'(MN_MAX));
			mdiv_d = clamp({1'b0, chain_q[19:10]}, 11'(MN_MAX));
			for (int i = 0; i < NUM_OUT; i++) begin
				half_d[i]  = chain_q[34 + 14*i];
				post_d[i]  = clamp({1'b0, chain_q[20+14*i +: 10]},
				    chain_q[34+14*i] ? 11'(POST_MAX_HALF) : 11'(POST_MAX_OTHER));
				// Chain field is four bits: only the lower part of the span
				dly_d[i]   = {1'b0, chain_q[30+14*i +: 4]};
			end
		end else if (wr_pend_q) begin
			case (addr_q)
				OFS_CTRL: ctrl_d = hwdata;
				// [RL1] Pre-divide and multiply 1..512
				OFS_NDIV: ndiv_d = clamp(hwdata[10:0], 11'(MN_MAX));
				OFS_MDIV: mdiv_d = clamp(hwdata[10:0], 11'(MN_MAX));
				default: begin
					for (int i = 0; i < NUM_OUT; i++) begin
						if (addr_q == OFS_POST0 + 8'(4*i)) begin
							// [RL2] Half-period allows 1..1024
							// [RL3] Other duty limited to 512
							half_d[i] = hwdata[POST_HALF_BIT];
							post_d[i] = clamp(hwdata[10:0],
							    hwdata[POST_HALF_BIT] ? 11'(POST_MAX_HALF)
							                          : 11'(POST_MAX_OTHER));
							// [RL7] 250 ps steps, 0..24, centre 12
							dly_d[i] = (hwdata[24:20] > 5'(2*DELAY_STEPS))
							    ? 5'(2*DELAY_STEPS) : hwdata[24:20];
						end
					end
				end
			endcase
		end
	end
	// ==========================================================
	// AHB-Lite slave, zero wait states
	always_comb begin
		hrdata_d = 32'h0000_0000;
		case (haddr[7:0])
			OFS_CTRL:   hrdata_d = ctrl_q;
			OFS_STATUS: hrdata_d = {26'h0, relock_timeout, reference_loss_flag,
			    secondary_missing_flag, primary_missing_flag, ref_select,
			    pll_locked};
			OFS_NDIV:   hrdata_d = {22'h0, ndiv_q};
			OFS_MDIV:   hrdata_d = {22'h0, mdiv_q};
			default: begin
				for (int i = 0; i < NUM_OUT; i++)
					if (haddr[7:0] == OFS_POST0 + 8'(4*i))
						hrdata_d = {7'h0, dly_q[i], 3'h0, half_q[i], 6'h0,
						    post_q[i]};
			end
		endcase
	end
	wire acc = hsel & htrans[1] & hready;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST; ndiv_q <= DIV_RST; mdiv_q <= DIV_RST;
			half_q <= '1;
			for (int i = 0; i < NUM_OUT; i++) begin
				post_q[i] <= DIV_RST;
				dly_q[i]  <= 5'(DELAY_STEPS);
			end
			wr_pend_q <= 1'b0; rd_pend_q <= 1'b0; addr_q <= 8'h00;
			hrdata <= 32'h0000_0000; hreadyout <= 1'b1; hresp <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d; ndiv_q <= ndiv_d; mdiv_q <= mdiv_d;
			half_q <= half_d; post_q <= post_d; dly_q <= dly_d;
			wr_pend_q <= acc & hwrite;
			rd_pend_q <= acc & ~hwrite;
			addr_q    <= acc ? haddr[7:0] : addr_q;
			hrdata    <= (acc & ~hwrite) ? hrdata_d : hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
	// ==========================================================
	// Reference sensing and switchover
	logic [4:0] miss_a_q, miss_b_q, miss_a_d, miss_b_d;
	logic       sel_d, relock_busy_q, relock_busy_d, timeout_d;
	logic [21:0] relock_cnt_q, relock_cnt_d;
	logic       sw_req_q;
	always_comb begin
		// [RL20] Missing counters per input
		miss_a_d = (ref_a_q != s2_q[0]) ? 5'h00 :
		    (miss_a_q == 5'(MISS_TIMEOUT) ? miss_a_q : miss_a_q + 5'h01);
		miss_b_d = (ref_b_q != s2_q[1]) ? 5'h00 :
		    (miss_b_q == 5'(MISS_TIMEOUT) ? miss_b_q : miss_b_q + 5'h01);
		sel_d = ref_select;
		// [RL9] Auto move to secondary on loss
		if (ctrl_q[CTRL_AUTO_BIT] && !ref_select &&
		    miss_a_q == 5'(MISS_TIMEOUT))
			sel_d = 1'b1;
		// [RL10] Manual request toggles selection
		if (sw_req && !sw_req_q)
			sel_d = ~ref_select;
		// [RL13] Relock watchdog, 100 us bound
		relock_busy_d = relock_busy_q;
		relock_cnt_d  = relock_cnt_q;
		timeout_d     = relock_timeout;
		if (sel_d != ref_select) begin
			relock_busy_d = 1'b1;
			relock_cnt_d  = 22'h0;
			timeout_d     = 1'b0;
		end else if (relock_busy_q) begin
			if (pll_locked) begin
				relock_busy_d = 1'b0;
			end else if (relock_cnt_q == 22'(RELOCK_LIMIT - 1)) begin
				relock_busy_d = 1'b0;
				timeout_d     = 1'b1;
			end else begin
				relock_cnt_d = relock_cnt_q + 22'h1;
			end
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miss_a_q <= 5'h00; miss_b_q <= 5'h00; ref_select <= 1'b0;
			sw_req_q <= 1'b0; relock_busy_q <= 1'b0;
			relock_cnt_q <= 22'h0; relock_timeout <= 1'b0;
			primary_missing_flag <= 1'b0; secondary_missing_flag <= 1'b0;
			reference_loss_flag <= 1'b0;
		end else begin
			miss_a_q <= miss_a_d; miss_b_q <= miss_b_d;
			// [RL12] Select only changes in clean domain
			ref_select <= sel_d;
			sw_req_q <= sw_req; relock_busy_q <= relock_busy_d;
			relock_cnt_q <= relock_cnt_d; relock_timeout <= timeout_d;
			primary_missing_flag   <= miss_a_d == 5'(MISS_TIMEOUT);
			secondary_missing_flag <= miss_b_d == 5'(MISS_TIMEOUT);
			reference_loss_flag <= (miss_a_d == 5'(MISS_TIMEOUT)) |
			    (miss_b_d == 5'(MISS_TIMEOUT));
		end
	end
	// ==========================================================
	// Post-scale counters on the oscillator clock
	// [RL4] Target set by loop: ref * m / n
	// [RL6] Phase taps of eight per period live in analogue loop
	// [RL8] First six outputs internal, rest external
	// [RL5] Independent divider per output
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_post
		logic [9:0] cnt_q;
		always_ff @(posedge vco_clock or posedge rst) begin
			if (rst) begin
				cnt_q        <= 10'h000;
				post_outs[g] <= 1'b0;
			end else if (cnt_q >= post_q[g] - 10'h001) begin
				cnt_q        <= 10'h000;
				post_outs[g] <= (post_q[g] == 10'h001) ? ~post_outs[g] : 1'b1;
			end else begin
				cnt_q        <= cnt_q + 10'h001;
				post_outs[g] <= (cnt_q + 10'h001) <
				    (half_q[g] ? (post_q[g] >> 1) : 10'h001);
			end
		end
	end
	// [RL19] 160 bits at 22 MHz take about 7.3 us
endmodule // pdr_top

// ===== hdl/pdr_pkg.sv
// Package: constants for the clock synthesiser digital control block.
// Assumes one 40 MHz system clock and an AHB-Lite register port.
package pdr_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS     = 25000;
	localparam int RELOCK_MAX_US     = 100;
	localparam int RELOCK_CYCLES     = RELOCK_MAX_US * 1000000 / CLK_PERIOD_PS;
	localparam int MISS_TIMEOUT      = 16;
	localparam int DELAY_STEP_PS     = 250;
	localparam int DELAY_SPAN_PS     = 3000;
	localparam int DELAY_STEPS       = DELAY_SPAN_PS / DELAY_STEP_PS;
	localparam int PHASE_STEPS       = 8;
	// ==========================================================
	// Divider ranges
	localparam int MN_MAX            = 512;
	localparam int POST_MAX_HALF     = 1024;
	localparam int POST_MAX_OTHER    = 512;
	localparam int NUM_OUT           = 10;
	localparam int NUM_INT_OUT       = 6;
	localparam int CHAIN_LEN         = 160;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_NDIV   = 8'h08;
	localparam logic [7:0] OFS_MDIV   = 8'h0C;
	localparam logic [7:0] OFS_POST0  = 8'h10;
	// Field positions
	localparam int CTRL_AUTO_BIT      = 0;
	localparam int CTRL_FEXT_BIT      = 1;
	localparam int POST_HALF_BIT      = 16;
	// Reset values
	localparam logic [9:0] DIV_RST    = 10'h001;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
endpackage

// ===== tb/pdr_checker.sv
// Checker: port-level properties of the synthesiser control block.
// Assumes it is bound onto pdr_top; one clock domain.
`timescale 1ns/1ps
module pdr_checker
	import pdr_pkg::*;
#(
	parameter int RELOCK_LIMIT = 50
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        primary_ref_input,
	input wire logic        pll_locked,
	input wire logic        switch_request,
	input wire logic        ref_select,
	input wire logic        primary_missing_flag,
	input wire logic        secondary_missing_flag,
	input wire logic        reference_loss_flag,
	input wire logic        relock_timeout
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ====
	// Helpers
	logic [15:0] idle_d, idle_q, since_d, since_q;
	logic        pri_q, sel_q, rs_d, rs_q, ru_d, ru_q, take;
	always_comb begin
		take = hsel & htrans[1] & hready & !hwrite & (haddr[31:8] == 24'h0);
		idle_d = (primary_ref_input != pri_q) ? 16'h0 : idle_q + 16'h1;
		since_d = (ref_select != sel_q) ? 16'h0 : since_q + 16'h1;
		rs_d = take & (haddr[7:0] == OFS_STATUS);
		ru_d = take & (haddr[7:0] > 8'h34);
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{idle_q, since_q, pri_q, sel_q, rs_q, ru_q} <= '0;
		end else begin
			{idle_q, since_q} <= {idle_d, since_d};
			{pri_q, sel_q, rs_q, ru_q} <= {primary_ref_input, ref_select, rs_d, ru_d};
		end
	end
	// ====
	// Properties
	property p_miss;
		$rose(primary_missing_flag) |-> idle_q >= 16'(MISS_TIMEOUT);
	endproperty
	a_miss: assert property (p_miss) else $error("missing flag too early");
	property p_loss;
		reference_loss_flag |-> primary_missing_flag || secondary_missing_flag
			|| $past(primary_missing_flag) || $past(secondary_missing_flag);
	endproperty
	a_loss: assert property (p_loss) else $error("loss without missing");
	property p_manual;
		$rose(switch_request) |-> ##[1:4] $changed(ref_select);
	endproperty
	a_manual: assert property (p_manual) else $error("request ignored");
	property p_back;
		$fell(ref_select) |-> $past(switch_request) || $past(switch_request, 2)
			|| $past(switch_request, 3);
	endproperty
	a_back: assert property (p_back) else $error("unrequested return");
	property p_auto;
		$rose(primary_missing_flag) && !ref_select |-> ##[0:4] ref_select;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto switch");
	property p_relock;
		$rose(relock_timeout) |-> since_q >= 16'(RELOCK_LIMIT - 2)
			&& !$past(pll_locked);
	endproperty
	a_relock: assert property (p_relock) else $error("early timeout");
	property p_stat;
		rs_q |-> hrdata[2:1] == {$past(primary_missing_flag), $past(ref_select)};
	endproperty
	a_stat: assert property (p_stat) else $error("status mismatch");
	property p_unmap;
		ru_q |-> hrdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_sel;
		$changed(ref_select) |=> $stable(ref_select)[*2];
	endproperty
	a_sel: assert property (p_sel) else $error("selection glitch");
	c_auto: cover property ($rose(ref_select));
	c_back: cover property ($fell(ref_select));
	c_tmo: cover property ($rose(relock_timeout));
endmodule // pdr_checker

// ===== tb/pdr_shift_model.sv
// Model of system logic loading the reconfiguration chain.
// Assumes 160-bit frames sent least significant bit first.
`timescale 1ns/1ps
module pdr_shift_model (
	output logic shift_clock,
	output logic shift_data,
	output logic shift_clear
);
	// 22 MHz; the clock stands still between frames
	localparam real HALF = 22.727;
	// Clear at start so the chain holds no unknowns
	initial begin
		{shift_clock, shift_data, shift_clear} = 3'b001;
		#(HALF);
		shift_clear = 1'b0;
	end
	// clear, then a bit per rising edge
	task automatic send(input logic [159:0] v);
		shift_clear = 1'b1;
		#(HALF);
		shift_clear = 1'b0;
		for (int i = 0; i < 160; i++) begin
			shift_data = v[i];
			#(HALF);
			shift_clock = 1'b1;
			#(HALF);
			shift_clock = 1'b0;
		end
		// Held value is not guaranteed after the frame
		shift_data = ~v[159];
	endtask
endmodule // pdr_shift_model

// ===== tb/pdr_top_tb.sv
// Testbench: registers, switchover and chain loading of pdr_top.
// Assumes the checker and shift model are compiled first.
`timescale 1ns/1ps
module pdr_top_tb
	import pdr_pkg::*;
;
	localparam int RL = 50;
	logic         clock, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]  haddr, hwdata, hrdata, rd, e;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic         primary_ref_input, secondary_ref_input, vco_clock;
	logic         pll_locked, switch_request, shift_clock, shift_data;
	logic         shift_clear, ref_select, relock_timeout, pri_run;
	logic         primary_missing_flag, secondary_missing_flag;
	logic         reference_loss_flag;
	logic [9:0]   post_outs;
	logic [159:0] frame;
	int           err_total, cmp_count, cyc, seed, v;
	int           corner[4] = '{0, 512, 513, 1023};
	realtime      t0;
	assign hready = hreadyout;
	pdr_top #(.RELOCK_LIMIT(RL)) dut (.clock, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.primary_ref_input, .secondary_ref_input, .vco_clock, .pll_locked,
		.switch_request, .shift_clock, .shift_data, .shift_clear, .ref_select,
		.primary_missing_flag, .secondary_missing_flag, .reference_loss_flag,
		.relock_timeout, .post_outs);
	pdr_shift_model sm (.shift_clock, .shift_data, .shift_clear);
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		vco_clock = 1'b0;
		forever #3 vco_clock = ~vco_clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (pri_run && cyc[0]) primary_ref_input <= ~primary_ref_input;
		if (!cyc[0]) secondary_ref_input <= ~secondary_ref_input;
		if (cyc == 20000) begin
			err_total++;
			final_report;
		end
	end
	// ====
	// Bench tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, w};
		do @(posedge clock); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	function automatic logic [31:0] clampv(input int x, input int mx);
		return (x < 1) ? 32'h1 : (x > mx) ? 32'(mx) : 32'(x);
	endfunction
	task automatic final_report;
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ====
	// Main sequence
	initial begin
		{seed, err_total, cmp_count, cyc} = {32'd39336, 96'h0};
		{rst, hsel, hwrite, pri_run, pll_locked, switch_request} = 6'b100110;
		{primary_ref_input, secondary_ref_input, htrans, hsize} = 7'b0000010;
		{haddr, hwdata} = 64'h0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		bus(0, OFS_CTRL, 0);
		chk(rd, CTRL_RST);
		bus(0, OFS_NDIV, 0);
		chk(rd, {22'h0, DIV_RST});
		bus(0, 8'h80, 0);
		chk(rd, 32'h0);
		chk(hresp, 32'h0);
		for (int i = 0; i < 10; i++) begin
			v = (i < 4) ? corner[i] : $random(seed) & 32'h3FF;
			bus(1, OFS_NDIV, v);
			bus(1, OFS_MDIV, 1023 - v);
			bus(0, OFS_NDIV, 0);
			chk(rd & 32'h3FF, clampv(v, MN_MAX));
			bus(0, OFS_MDIV, 0);
			chk(rd & 32'h3FF, clampv(1023 - v, MN_MAX));
			bus(1, OFS_POST0 + 8'(4 * i), {15'h0, i[0], 6'h0, v[9:0]});
			bus(0, OFS_POST0 + 8'(4 * i), 0);
			e = clampv(v, i[0] ? POST_MAX_HALF : POST_MAX_OTHER);
			chk(rd & 32'h103FF, {15'h0, i[0], 6'h0, e[9:0]});
		end
		// Post counter 1: divide 5, half duty, delay above span
		bus(1, OFS_POST0 + 8'h04, 32'h01F1_0005);
		bus(0, OFS_POST0 + 8'h04, 0);
		chk(rd, 32'h0181_0005);
		repeat (2) @(posedge post_outs[1]);
		t0 = $realtime;
		@(posedge post_outs[1]);
		chk(32'(int'(($realtime - t0) / 6.0)), 32'h5);
		// Chain frame with random pre-divide
		v = ($random(seed) & 32'h1FF) + 1;
		frame = {140'h0, 10'h007, v[9:0]};
		t0 = $realtime;
		sm.send(frame);
		repeat (8) @(posedge clock);
		chk(($realtime - t0) < 20000.0, 32'h1);
		bus(0, OFS_NDIV, 0);
		chk(rd & 32'h3FF, v);
		bus(0, OFS_MDIV, 0);
		chk(rd & 32'h3FF, 32'h7);
		// Primary stops while lock is lost
		{pri_run, pll_locked} <= 2'b00;
		for (int i = 0; i < 60 && ref_select !== 1'b1; i++) @(posedge clock);
		bus(0, OFS_STATUS, 0);
		chk(rd & 32'h1E, 32'h16);
		for (int i = 0; i < 2 * RL && relock_timeout !== 1'b1; i++) @(posedge clock);
		chk(relock_timeout, 32'h1);
		{pri_run, pll_locked} <= 2'b11;
		repeat (40) @(posedge clock);
		chk(primary_missing_flag, 32'h0);
		// Bench switches by request, not by sensing
		for (int i = 0; i < 2; i++) begin
			switch_request <= pll_locked;
			repeat (6) @(posedge clock);
			switch_request <= 1'b0;
			repeat (6) @(posedge clock);
			chk(ref_select, i[0]);
		end
		final_report;
	end
endmodule // pdr_top_tb
bind pdr_top pdr_checker #(.RELOCK_LIMIT(RELOCK_LIMIT)) chk_i (.clock, .rst,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .primary_ref_input,
	.pll_locked, .switch_request, .ref_select, .primary_missing_flag,
	.secondary_missing_flag, .reference_loss_flag, .relock_timeout);
